// ===== core/ddi_defines.svh
// constants for the memory-device init and command tracking block
// assumes a single 10 MHz core clock; included by ddi_core
`ifndef DDI_DEFINES_SVH
`define DDI_DEFINES_SVH

`define DDI_CLK_MHZ 10
`define DDI_INTINIT_TIME_US 500
`define DDI_INTINIT_CYCLES (`DDI_INTINIT_TIME_US * `DDI_CLK_MHZ)
`define DDI_DLL_LOCK_CYCLES 512
`define DDI_CALIB_INIT_CYCLES 512

// {ras_n, cas_n, we_n} with select low
`define DDI_CMD_MODE_WRITE 3'h0
`define DDI_CMD_ACTIVATE 3'h3
`define DDI_CMD_PRECHARGE 3'h2
`define DDI_CMD_WRITE 3'h4
`define DDI_CMD_READ 3'h5
`define DDI_CMD_CALIB 3'h6
`define DDI_CMD_NOP 3'h7

// address fields
`define DDI_BIT_AUTO_PRECHARGE 10
`define DDI_BIT_BURST_CHOP 12
`define DDI_BIT_DLL_RESET 8
`define DDI_BIT_BURST_TYPE 3
`define DDI_MR0_BL_LSB 0
`define DDI_BL_FIXED8 2'h0
`define DDI_BL_ON_THE_FLY 2'h1
`define DDI_BL_FIXED4 2'h2
`define DDI_LAST_BEAT_EIGHT 2'h3
`define DDI_LAST_BEAT_CHOP 2'h1

`endif

// ===== core/ddi_pkg.sv
// types for the memory-device init and command tracking block
// assumes ddi_defines.svh is on the include path
package ddi_pkg;
	typedef enum logic [2:0] {
		DDI_PH_INTINIT = 3'h1,
		DDI_PH_WAIT_CKE = 3'h2,
		DDI_PH_RUN = 3'h4
	} ddi_phase_t;

	typedef struct packed {
		ddi_phase_t phase;
		logic [15:0] init_cnt;
		logic cke_q;
		logic [3:0][12:0] mode_reg;
		logic [3:0] mr_written;
		logic [15:0] dll_cnt;
		logic dll_busy;
		logic dll_locked;
		logic [15:0] calib_cnt;
		logic calib_busy;
		logic calib_done;
		logic dev_ready;
		logic odt_on;
		logic init_busy;
		logic [7:0] bank_open;
		logic [7:0][12:0] open_row;
		logic burst_active;
		logic burst_write;
		logic burst_chop;
		logic burst_autopre;
		logic burst_interleave;
		logic [2:0] burst_bank;
		logic [9:0] burst_col;
		logic [1:0] beat;
		logic [2:0] word_lo;
		logic [2:0] word_hi;
	} ddi_state_t;
endpackage

// ===== core/ddi_reset_sync.sv
// reset release synchroniser
// assumes arst_n may drop at any time; release is taken on clk
`timescale 1ns/100ps
module ddi_reset_sync (
	input wire logic clk,
	input wire logic arst_n,
	output logic rst_n
);
	logic stage1;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stage1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			stage1 <= 1'b1;
			rst_n <= stage1;
		end
	end
endmodule // ddi_reset_sync

// ===== core/ddi_core.sv
// memory-device side: init tracking, mode registers, bank rows, burst order
// assumes command pins come from controller logic on clk; arst_n is the device reset pin
`timescale 1ns/100ps
`include "ddi_defines.svh"
module ddi_core
	import ddi_pkg::*;
#(
	parameter int INTINIT_CYCLES = `DDI_INTINIT_CYCLES,
	parameter int DLL_LOCK_CYCLES = `DDI_DLL_LOCK_CYCLES,
	parameter int CALIB_INIT_CYCLES = `DDI_CALIB_INIT_CYCLES
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [2:0] bank_select_bits,
	input wire logic [12:0] addr,
	input wire logic termination_control_input,
	output logic dev_ready,
	output logic odt_on,
	output logic init_busy,
	output logic [3:0][12:0] mode_reg,
	output logic dll_locked,
	output logic calib_done,
	output logic [7:0] bank_open,
	output logic [7:0][12:0] open_row,
	output logic burst_active,
	output logic burst_write,
	output logic burst_chop,
	output logic burst_autopre,
	output logic [2:0] burst_bank,
	output logic [9:0] burst_col,
	output logic [2:0] word_lo,
	output logic [2:0] word_hi
);
	localparam logic [15:0] INTINIT_LAST = 16'(INTINIT_CYCLES - 1);
	localparam logic [15:0] DLL_LAST = 16'(DLL_LOCK_CYCLES - 1);
	localparam logic [15:0] CALIB_LAST = 16'(CALIB_INIT_CYCLES - 1);

	localparam ddi_state_t RESET_STATE = '{phase: DDI_PH_INTINIT, init_busy: 1'b1, default: '0};

	logic rst_n;
	ddi_state_t st;
	ddi_state_t next_st;

	ddi_reset_sync u_rst (
		.clk(clk),
		.arst_n(arst_n),
		.rst_n(rst_n)
	);

	// order of the word carried in each half clock
	function automatic logic [2:0] ddi_word(input logic [2:0] start, input logic [2:0] idx,
			input logic interleave, input logic wr, input logic chop);
		logic [2:0] w;
		w = 3'h0;
		if (wr) begin
			// writes always land from the group base
			w = chop ? {start[2], idx[1:0]} : idx;
		end else if (interleave) begin
			w = start ^ idx;
		end else begin
			w = {start[2] ^ idx[2], 2'(start[1:0] + idx[1:0])};
		end
		return w;
	endfunction

	logic cmd_valid;
	logic [2:0] cmd;
	logic [1:0] bl_mode;
	logic chop_now;
	logic [1:0] last_beat;

	always_comb begin
		// commands count only when clock enable was high on this and the last edge
		cmd_valid = st.cke_q && cke && !cs_n && (st.phase == DDI_PH_RUN);
		cmd = {ras_n, cas_n, we_n};
		bl_mode = st.mode_reg[0][`DDI_MR0_BL_LSB +: 2];
		chop_now = (bl_mode == `DDI_BL_FIXED4) ||
			((bl_mode == `DDI_BL_ON_THE_FLY) && !addr[`DDI_BIT_BURST_CHOP]);
		last_beat = st.burst_chop ? `DDI_LAST_BEAT_CHOP : `DDI_LAST_BEAT_EIGHT;

		next_st = st;
		next_st.cke_q = cke;

		unique case (st.phase)
			DDI_PH_INTINIT: begin
				// internal init runs on its own; pins are ignored
				next_st.init_cnt = 16'(st.init_cnt + 16'h1);
				if (st.init_cnt == INTINIT_LAST) begin
					next_st.phase = DDI_PH_WAIT_CKE;
				end
			end
			DDI_PH_WAIT_CKE: begin
				if (cke) begin
					next_st.phase = DDI_PH_RUN;
				end
			end
			DDI_PH_RUN: begin
			end
		endcase

		// lock and calibration timers
		if (st.dll_busy) begin
			next_st.dll_cnt = 16'(st.dll_cnt + 16'h1);
			if (st.dll_cnt == DLL_LAST) begin
				next_st.dll_busy = 1'b0;
				next_st.dll_locked = 1'b1;
			end
		end
		if (st.calib_busy) begin
			next_st.calib_cnt = 16'(st.calib_cnt + 16'h1);
			if (st.calib_cnt == CALIB_LAST) begin
				next_st.calib_busy = 1'b0;
				next_st.calib_done = 1'b1;
			end
		end

		// burst beats: one 8n word over four clocks (two clocks when chopped), two words per clock
		if (st.burst_active) begin
			next_st.beat = 2'(st.beat + 2'h1);
			if (st.beat == last_beat) begin
				next_st.burst_active = 1'b0;
				if (st.burst_autopre) begin
					next_st.bank_open[st.burst_bank] = 1'b0;
				end
			end
		end

		if (cmd_valid) begin
			unique case (cmd)
				`DDI_CMD_MODE_WRITE: begin
					// whole register replaced; the array is never touched
					if (!bank_select_bits[2]) begin
						next_st.mode_reg[bank_select_bits[1:0]] = addr;
						next_st.mr_written[bank_select_bits[1:0]] = 1'b1;
						if (bank_select_bits[1:0] == 2'h0 && addr[`DDI_BIT_DLL_RESET]) begin
							// dll reset bit clears itself
							next_st.mode_reg[0][`DDI_BIT_DLL_RESET] = 1'b0;
							next_st.dll_busy = 1'b1;
							next_st.dll_cnt = 16'h0;
							next_st.dll_locked = 1'b0;
						end
					end
				end
				`DDI_CMD_ACTIVATE: begin
					next_st.bank_open[bank_select_bits] = 1'b1;
					next_st.open_row[bank_select_bits] = addr;
				end
				`DDI_CMD_PRECHARGE: begin
					if (addr[`DDI_BIT_AUTO_PRECHARGE]) begin
						next_st.bank_open = 8'h0;
					end else begin
						next_st.bank_open[bank_select_bits] = 1'b0;
					end
				end
				`DDI_CMD_READ, `DDI_CMD_WRITE: begin
					if (st.bank_open[bank_select_bits]) begin
						next_st.burst_active = 1'b1;
						next_st.burst_write = (cmd == `DDI_CMD_WRITE);
						next_st.burst_chop = chop_now;
						next_st.burst_autopre = addr[`DDI_BIT_AUTO_PRECHARGE];
						next_st.burst_interleave = st.mode_reg[0][`DDI_BIT_BURST_TYPE];
						next_st.burst_bank = bank_select_bits;
						next_st.burst_col = addr[9:0];
						next_st.beat = 2'h0;
					end
				end
				`DDI_CMD_CALIB: begin
					if (addr[`DDI_BIT_AUTO_PRECHARGE]) begin
						next_st.calib_busy = 1'b1;
						next_st.calib_cnt = 16'h0;
						next_st.calib_done = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// words carried by the beat now being registered
		next_st.word_lo = ddi_word(next_st.burst_col[2:0], {next_st.beat, 1'b0},
			next_st.burst_interleave, next_st.burst_write, next_st.burst_chop);
		next_st.word_hi = ddi_word(next_st.burst_col[2:0], {next_st.beat, 1'b1},
			next_st.burst_interleave, next_st.burst_write, next_st.burst_chop);

		// ready only after all four registers, lock and calibration since reset
		next_st.dev_ready = (next_st.phase == DDI_PH_RUN) && (&next_st.mr_written) &&
			next_st.dll_locked && next_st.calib_done;

		// termination follows its input only once clock enable has been registered
		next_st.odt_on = (next_st.phase == DDI_PH_RUN) && termination_control_input;
		next_st.init_busy = (next_st.phase != DDI_PH_RUN);

		if (!ce) begin
			next_st = st;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= RESET_STATE;
		end else begin
			st <= next_st;
		end
	end

	always_comb begin
		dev_ready = st.dev_ready;
		odt_on = st.odt_on;
		init_busy = st.init_busy;
		mode_reg = st.mode_reg;
		dll_locked = st.dll_locked;
		calib_done = st.calib_done;
		bank_open = st.bank_open;
		open_row = st.open_row;
		burst_active = st.burst_active;
		burst_write = st.burst_write;
		burst_chop = st.burst_chop;
		burst_autopre = st.burst_autopre;
		burst_bank = st.burst_bank;
		burst_col = st.burst_col;
		word_lo = st.word_lo;
		word_hi = st.word_hi;
	end
endmodule // ddi_core

// ===== tb/ddi_core_monitor.sv
// port checker for ddi_core
// bound to ddi_core; one clock, reset pin arst_n
`timescale 1ns/100ps
module ddi_core_monitor #(
	parameter int DLL_LOCK_CYCLES = 512,
	parameter int CALIB_INIT_CYCLES = 512
) (
	input logic clk,
	input logic arst_n,
	input logic ce,
	input logic cke,
	input logic cs_n,
	input logic ras_n,
	input logic cas_n,
	input logic we_n,
	input logic [2:0] bank_select_bits,
	input logic [12:0] addr,
	input logic odt_on,
	input logic init_busy,
	input logic dev_ready,
	input logic dll_locked,
	input logic calib_done,
	input logic [3:0][12:0] mode_reg,
	input logic [7:0] bank_open,
	input logic [7:0][12:0] open_row,
	input logic burst_active,
	input logic burst_chop,
	input logic [2:0] word_lo,
	input logic [2:0] word_hi
);
	localparam int DLL_HI = DLL_LOCK_CYCLES + 2;
	localparam int CAL_HI = CALIB_INIT_CYCLES + 2;
	logic cke_d;
	wire [2:0] op = {ras_n, cas_n, we_n};
	wire take = ce && cke && cke_d && !cs_n && !init_busy;
	wire mode_register_write_cmd = take && op == 3'h0 && !bank_select_bits[2];
	// dll reset bit self-clears
	wire [12:0] mval = addr & (bank_select_bits[1:0] == 2'h0 ? 13'h1eff : 13'h1fff);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			cke_d <= 1'b0;
		else if (ce)
			cke_d <= cke;
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	property p_mrs; mode_register_write_cmd |=> mode_reg[$past(bank_select_bits[1:0])] == $past(mval); endproperty
	a_mrs: assert property (p_mrs) else $error("mode write lost");
	property p_dll; mode_register_write_cmd && bank_select_bits == 3'h0 && addr[8] |=> !dll_locked ##[1:DLL_HI] dll_locked; endproperty
	a_dll: assert property (p_dll) else $error("dll lock");
	property p_cal; take && op == 3'h6 && addr[10] |=> !calib_done ##[1:CAL_HI] calib_done; endproperty
	a_cal: assert property (p_cal) else $error("calibration");
	property p_rdy; dev_ready |-> dll_locked && calib_done && !init_busy; endproperty
	a_rdy: assert property (p_rdy) else $error("ready early");
	property p_act;
		take && op == 3'h3 |=> bank_open[$past(bank_select_bits)] && open_row[$past(bank_select_bits)] == $past(addr);
	endproperty
	a_act: assert property (p_act) else $error("row not open");
	property p_bl8; $rose(burst_active) && !burst_chop |-> burst_active[*4] ##1 !burst_active; endproperty
	a_bl8: assert property (p_bl8) else $error("burst length");
	property p_bc4; $rose(burst_active) && burst_chop |-> burst_active[*2] ##1 !burst_active; endproperty
	a_bc4: assert property (p_bc4) else $error("chopped burst length");
	property p_odt_init; init_busy |-> !odt_on; endproperty
	a_odt_init: assert property (p_odt_init) else $error("termination during init");
	property p_pair; burst_active |-> word_lo[2] == word_hi[2] && word_lo != word_hi; endproperty
	a_pair: assert property (p_pair) else $error("word pair");
	property p_odt; !cke_d |-> !odt_on; endproperty
	a_odt: assert property (p_odt) else $error("termination early");
	c_rdy: cover property ($rose(dev_ready));
	c_wr: cover property (take && op == 3'h4);
	c_chop: cover property ($rose(burst_active) && burst_chop);
endmodule // ddi_core_monitor

bind ddi_core ddi_core_monitor #(.DLL_LOCK_CYCLES(DLL_LOCK_CYCLES), .CALIB_INIT_CYCLES(CALIB_INIT_CYCLES)) mon (.*);

// ===== tb/ddi_ctrl_model.sv
// controller model: reset pin, clock enable, commands
// tasks called by the bench; pins move 1 ns after clk
`timescale 1ns/100ps
module ddi_ctrl_model #(
	parameter int INIT_WAIT = 26
) (
	input logic clk,
	output logic arst_n = 1'b0,
	output logic cke = 1'b0,
	output logic cs_n = 1'b1,
	output logic ras_n = 1'b1,
	output logic cas_n = 1'b1,
	output logic we_n = 1'b1,
	output logic [2:0] bank_select_bits = 3'h0,
	output logic [12:0] addr = 13'h0000,
	output logic termination_control_input = 1'b1
);
	task automatic cmd(input logic [2:0] op, input logic [2:0] ba, input logic [12:0] a, input int n);
		@(posedge clk);
		#1 cs_n = 1'b0;
		{ras_n, cas_n, we_n, bank_select_bits, addr} = {op, ba, a};
		@(posedge clk);
		#1 cs_n = 1'b1;
		// deselected pins flip so stale values are never trusted
		{ras_n, cas_n, we_n, bank_select_bits, addr} = ~{op, ba, a};
		repeat (n) @(posedge clk);
	endtask
	task automatic rst(input int n, input logic t);
		#1 cke = 1'b0;
		arst_n = 1'b0;
		termination_control_input = t;
		repeat (n) @(posedge clk);
		#1 arst_n = 1'b1;
	endtask
	task automatic init(input logic [3:0][12:0] v);
		repeat (INIT_WAIT) @(posedge clk);
		#1 cke = 1'b1;
		repeat (5) @(posedge clk);
		cmd(3'h0, 3'h2, v[2], 4);
		cmd(3'h0, 3'h3, v[3], 4);
		cmd(3'h0, 3'h1, v[1], 4);
		cmd(3'h0, 3'h0, v[0], 4);
		cmd(3'h6, 3'h0, 13'h0400, 0);
	endtask
endmodule // ddi_ctrl_model

// ===== tb/ddr3_sdram_init_sequence_test.sv
// bench for ddi_core: power-up, stable-power reset, bursts
// ddi_ctrl_model acts as controller; 10 MHz clk
`timescale 1ns/100ps
module ddr3_sdram_init_sequence_test;
	logic clk = 1'b0;
	logic ce = 1'b1;
	logic arst_n, cke, cs_n, ras_n, cas_n, we_n, termination_control_input;
	logic dev_ready, odt_on, init_busy, dll_locked, calib_done, burst_active, burst_write, burst_chop, burst_autopre;
	logic [2:0] bank_select_bits, burst_bank, word_lo, word_hi, b;
	logic [12:0] addr, a;
	logic [3:0][12:0] mode_reg, v;
	logic [7:0] bank_open;
	logic [7:0][12:0] open_row;
	logic [9:0] burst_col;
	logic [5:0] e;
	int mismatches = 0;
	int check_count = 0;
	int k;
	always #50 clk = ~clk;
	ddi_core #(.INTINIT_CYCLES(20), .DLL_LOCK_CYCLES(8), .CALIB_INIT_CYCLES(8)) DUT (.*);
	ddi_ctrl_model m (.*);
	function automatic logic [2:0] ord(logic [2:0] s, logic il, logic wr, logic ch, int i);
		logic [2:0] j = 3'(i);
		if (wr)
			s = ch ? {s[2], 2'h0} : 3'h0;
		return il ? {s[2] ^ j[2], s[1:0] ^ j[1:0]} : {s[2] ^ j[2], s[1:0] + j[1:0]};
	endfunction
	task automatic chk(input logic [13:0] got, input logic [13:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		if (mismatches == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		k = $urandom(62);
		for (int p = 0; p < 2; p++) begin
			m.rst(p ? 1 : 5, p == 0);
			repeat (3) @(posedge clk);
			#1 chk({odt_on, dev_ready, init_busy, dll_locked, calib_done}, 14'h4);
			v[2] = 13'($urandom);
			v[3] = 13'($urandom);
			v[1] = 13'($urandom) & 13'h1dba;
			v[0] = 13'($urandom) & 13'h1e74 | 13'h0101 | 13'(p * 8);
			m.init(v);
			for (k = 0; k < 40 && dev_ready !== 1'b1; k++) begin
				@(posedge clk);
				#1;
			end
			#1 chk({odt_on, dev_ready, dll_locked, calib_done}, {10'h0, p == 0, 3'h7});
			v[0][8] = 1'b0;
			for (int r = 0; r < 4; r++)
				chk(mode_reg[r], v[r]);
			for (int i = 0; i < 4; i++) begin
				b = 3'($urandom);
				a = 13'($urandom);
				m.cmd(3'h3, b, a, 0);
				chk({bank_open[b], open_row[b]}, {1'b1, a});
				a = {~i[1], 1'b0, 11'($urandom)};
				m.cmd(i[0] ? 3'h4 : 3'h5, b, a, 0);
				for (k = 0; k < (i[1] ? 4 : 8); k += 2) begin
					e = {ord(a[2:0], p[0], i[0], i[1], k), ord(a[2:0], p[0], i[0], i[1], k + 1)};
					chk({burst_active, word_lo, word_hi}, {1'b1, e});
					if (k == 0) begin
						chk({burst_write, burst_chop, burst_autopre, burst_bank}, {i[0], i[1], a[10], b});
						chk(burst_col, a[9:0]);
					end
					@(posedge clk);
					#1;
				end
				repeat (2) @(posedge clk);
				#1 chk(bank_open[b], !a[10]);
				// odd bursts close all banks, even ones only the bank in use
				m.cmd(3'h2, b, {2'h0, i[0], 10'h000}, 0);
				chk(bank_open, 8'h00);
			end
			a = 13'($urandom);
			m.cmd(3'h0, 3'h6, ~a, 0);
			chk(mode_reg[2], v[2]);
			// clock enable low freezes the block, so this write must not land
			ce = 1'b0;
			m.cmd(3'h0, 3'h2, ~a, 0);
			ce = 1'b1;
			chk(mode_reg[2], v[2]);
			m.cmd(3'h0, 3'h2, a, 0);
			chk(mode_reg[2], a);
		end
		final_report;
	end
	initial begin
		repeat (3000) @(posedge clk);
		mismatches++;
		final_report;
	end
endmodule // ddr3_sdram_init_sequence_test
